// File: logic/fssc_ctrl.v
// Fieldbus slave communication state machine with register port and data gating
// Behaviour
// - In Init, refuse mailbox traffic and all process data.
// - Pre-Operational request from Init accepted only when mailbox channel setup is valid.
// - Pre-Operational serves mailbox but withholds all process data.
// - Safe-Operational from Pre-Operational needs valid process channels, and clock settings when synchronised.
// - Safe-Operational returns inputs but does not apply received outputs.
// - Operational applies outputs and returns inputs.
// - State changes only on master requests, except a forced return to Init on a fieldbus deselect.
// - Cyclic data exchanged once every network cycle.
// - Acyclic data only as emergency, SDO request and SDO response.
// - Drive alarm sends an emergency message carrying its error code.
// - Application cycle aligned to Sync0 events.
// - Only synchronisation subindex 03h is writable; others refused.
// - Bus selection value 1, the default, selects this fieldbus.
// - Non-zero unique node number gives axis number node minus one.
// - Node number 0 to 127, default 0, effective after restart.
`timescale 1ns/1ps
`include "fssc_regs.vh"

module fssc_ctrl #(
  parameter PD_W = 32,
  parameter MB_W = 16
) (
  input  wire            i_clk,
  input  wire            i_srst,
  input  wire [7:0]      i_addr,
  input  wire [31:0]     i_wdata,
  input  wire            i_wr,
  input  wire            i_rd,
  output reg  [31:0]     o_rdata,
  output wire            o_irq,
  input  wire            i_mbx_sm_ok,
  input  wire            i_pd_sm_ok,
  input  wire            i_dc_ok,
  input  wire            i_restart,
  input  wire            i_node_unique,
  output wire            o_bus_active,
  output wire [3:0]      o_al_state,
  output wire            o_axis_forced,
  output reg  [6:0]      o_axis_number,
  input  wire            i_mbx_rx_valid,
  input  wire [3:0]      i_mbx_rx_svc,
  input  wire [MB_W-1:0] i_mbx_rx_data,
  output reg             o_mbx_rx_ack,
  output reg             o_mbx_rx_nak,
  output reg             o_sdo_req_valid,
  output reg  [MB_W-1:0] o_sdo_req_data,
  input  wire            i_sdo_rsp_valid,
  input  wire [MB_W-1:0] i_sdo_rsp_data,
  output reg             o_mbx_tx_valid,
  output reg  [3:0]      o_mbx_tx_svc,
  output reg  [MB_W-1:0] o_mbx_tx_data,
  input  wire            i_mbx_tx_ready,
  input  wire            i_alarm,
  input  wire [15:0]     i_alarm_code,
  input  wire            i_sync0,
  input  wire            i_pd_out_valid,
  input  wire [PD_W-1:0] i_pd_out_data,
  input  wire [PD_W-1:0] i_app_in_data,
  output reg             o_app_cycle,
  output reg             o_app_out_valid,
  output reg  [PD_W-1:0] o_app_out_data,
  output reg             o_pd_in_valid,
  output reg  [PD_W-1:0] o_pd_in_data
);

  reg [3:0]              state_q;
  reg [3:0]              req_q;
  reg                    err_q;
  reg [15:0]             err_code_q;
  reg                    dc_mode_q;
  reg [15:0]             sync_param_q;
  reg [3:0]              bus_sel_q;
  reg [6:0]              node_pend_q;
  reg [6:0]              node_act_q;
  reg [`FSSC_IRQ_W-1:0]  irq_stat_q;
  reg [`FSSC_IRQ_W-1:0]  irq_en_q;
  reg                    emcy_pend_q;
  reg [15:0]             emcy_code_q;
  reg                    rsp_pend_q;
  reg [MB_W-1:0]         rsp_data_q;
  reg [PD_W-1:0]         pd_out_q;
  reg                    pd_out_seen_q;

  wire                   wr_ctrl;
  wire [3:0]             req_state;
  wire [15:0]            trans_err;
  wire                   mbx_open;
  wire                   pd_in_open;
  wire                   pd_out_open;
  wire                   net_cycle;
  wire [`FSSC_IRQ_W-1:0] irq_set;
  wire [`FSSC_IRQ_W-1:0] irq_clr;
  wire                   sync_wr;
  wire                   sync_ok;
  wire                   emcy_fire;
  wire                   rsp_fire;
  wire                   tx_free;

  // Checks one requested transition; returns an error code or none
  function [15:0] fssc_check;
    input [3:0] cur;
    input [3:0] req;
    input       mbx_ok;
    input       pd_ok;
    input       dc_mode;
    input       dc_ok;
    begin
      fssc_check = `FSSC_ERR_NONE;
      case (req)
        `FSSC_ST_INIT: begin
          fssc_check = `FSSC_ERR_NONE;
        end
        `FSSC_ST_PREOP: begin
          if (cur == `FSSC_ST_INIT && !mbx_ok) begin
            fssc_check = `FSSC_ERR_MBX_CFG;
          end
        end
        `FSSC_ST_SAFEOP: begin
          if (cur == `FSSC_ST_INIT) begin
            fssc_check = `FSSC_ERR_BADREQ;
          end else if (cur == `FSSC_ST_PREOP && !pd_ok) begin
            fssc_check = `FSSC_ERR_PD_CFG;
          end else if (cur == `FSSC_ST_PREOP && dc_mode && !dc_ok) begin
            fssc_check = `FSSC_ERR_DC_CFG;
          end
        end
        `FSSC_ST_OP: begin
          if (cur != `FSSC_ST_SAFEOP && cur != `FSSC_ST_OP) begin
            fssc_check = `FSSC_ERR_BADREQ;
          end
        end
        default: begin
          fssc_check = `FSSC_ERR_BADREQ;
        end
      endcase
    end
  endfunction

  assign wr_ctrl     = i_wr && (i_addr == `FSSC_ADDR_AL_CTRL);
  assign req_state   = i_wdata[3:0];
  assign trans_err   = fssc_check(state_q, req_state, i_mbx_sm_ok, i_pd_sm_ok,
                                  dc_mode_q, i_dc_ok);
  assign o_bus_active = (bus_sel_q == `FSSC_BUS_SEL_THIS);
  assign o_al_state  = state_q;

  // Gating of traffic classes by communication state
  assign mbx_open    = (state_q != `FSSC_ST_INIT);
  assign pd_in_open  = (state_q == `FSSC_ST_SAFEOP) || (state_q == `FSSC_ST_OP);
  assign pd_out_open = (state_q == `FSSC_ST_OP);
  // In clock-synchronised mode Sync0 paces the cycle, else the output frame does
  assign net_cycle   = dc_mode_q ? i_sync0 : i_pd_out_valid;
  // State machine; only master writes move it, except a fieldbus deselect
  always @(posedge i_clk) begin
    if (i_srst) begin
      state_q    <= `FSSC_ST_INIT;
      req_q      <= `FSSC_ST_INIT;
      err_q      <= 1'b0;
      err_code_q <= `FSSC_ERR_NONE;
    end else if (!o_bus_active) begin
      state_q    <= `FSSC_ST_INIT;
    end else if (wr_ctrl) begin
      req_q <= req_state;
      if (trans_err == `FSSC_ERR_NONE) begin
        state_q    <= req_state;
        err_q      <= 1'b0;
        err_code_q <= `FSSC_ERR_NONE;
      end else begin
        err_q      <= 1'b1;
        err_code_q <= trans_err;
      end
    end
  end

  // Synchronisation parameter write: one subindex is settable
  assign sync_wr = i_wr && (i_addr == `FSSC_ADDR_SYNC_PARAM);
  assign sync_ok = (i_wdata[`FSSC_SYNC_SUB_MSB:`FSSC_SYNC_SUB_LSB] == `FSSC_SYNC_SETTABLE);

  // Software configuration registers
  always @(posedge i_clk) begin
    if (i_srst) begin
      dc_mode_q    <= 1'b0;
      sync_param_q <= `FSSC_RST_SYNC_PARAM;
      bus_sel_q    <= `FSSC_RST_BUS_SEL;
      node_pend_q  <= `FSSC_RST_NODE;
      irq_en_q     <= {`FSSC_IRQ_W{1'b0}};
    end else if (i_wr) begin
      if (i_addr == `FSSC_ADDR_SYNC_MODE) begin
        dc_mode_q <= i_wdata[0];
      end else if (sync_wr && sync_ok) begin
        sync_param_q <= i_wdata[15:0];
      end else if (i_addr == `FSSC_ADDR_BUS_SEL) begin
        bus_sel_q <= i_wdata[3:0];
      end else if (i_addr == `FSSC_ADDR_NODE) begin
        node_pend_q <= i_wdata[6:0];
      end else if (i_addr == `FSSC_ADDR_IRQ_EN) begin
        irq_en_q <= i_wdata[`FSSC_IRQ_W-1:0];
      end
    end
  end

  // Node number survives soft reset and only takes effect on restart
  always @(posedge i_clk) begin
    if (i_restart) begin
      node_act_q <= node_pend_q;
    end
  end
  // Axis number forced only by a non-zero unique node number
  assign o_axis_forced = (node_act_q != `FSSC_RST_NODE) && i_node_unique;
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_axis_number <= 7'h00;
    end else begin
      o_axis_number <= o_axis_forced ? node_act_q - 7'h01 : 7'h00;
    end
  end
  // Mailbox receive: only SDO requests are served, and never in Init
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_mbx_rx_ack    <= 1'b0;
      o_mbx_rx_nak    <= 1'b0;
      o_sdo_req_valid <= 1'b0;
      o_sdo_req_data  <= {MB_W{1'b0}};
    end else begin
      o_mbx_rx_ack    <= 1'b0;
      o_mbx_rx_nak    <= 1'b0;
      o_sdo_req_valid <= 1'b0;
      if (i_mbx_rx_valid) begin
        if (mbx_open && i_mbx_rx_svc == `FSSC_SVC_SDO_REQ) begin
          o_mbx_rx_ack    <= 1'b1;
          o_sdo_req_valid <= 1'b1;
          o_sdo_req_data  <= i_mbx_rx_data;
        end else begin
          o_mbx_rx_nak <= 1'b1;
        end
      end
    end
  end

  // Mailbox send: emergencies take priority over SDO responses
  assign tx_free   = !o_mbx_tx_valid || i_mbx_tx_ready;
  assign emcy_fire = tx_free && mbx_open && emcy_pend_q;
  assign rsp_fire  = tx_free && mbx_open && rsp_pend_q && !emcy_pend_q;
  // Alarms raised in Init wait until the mailbox opens; a newer code replaces an older
  always @(posedge i_clk) begin
    if (i_srst) begin
      emcy_pend_q <= 1'b0;
      emcy_code_q <= 16'h0000;
      rsp_pend_q  <= 1'b0;
      rsp_data_q  <= {MB_W{1'b0}};
    end else begin
      if (i_alarm) begin
        emcy_pend_q <= 1'b1;
        emcy_code_q <= i_alarm_code;
      end else if (emcy_fire) begin
        emcy_pend_q <= 1'b0;
      end
      if (i_sdo_rsp_valid) begin
        rsp_pend_q <= 1'b1;
        rsp_data_q <= i_sdo_rsp_data;
      end else if (rsp_fire) begin
        rsp_pend_q <= 1'b0;
      end
    end
  end
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_mbx_tx_valid <= 1'b0;
      o_mbx_tx_svc   <= 4'h0;
      o_mbx_tx_data  <= {MB_W{1'b0}};
    end else if (emcy_fire) begin
      o_mbx_tx_valid <= 1'b1;
      o_mbx_tx_svc   <= `FSSC_SVC_EMCY;
      o_mbx_tx_data  <= emcy_code_q[MB_W-1:0];
    end else if (rsp_fire) begin
      o_mbx_tx_valid <= 1'b1;
      o_mbx_tx_svc   <= `FSSC_SVC_SDO_RSP;
      o_mbx_tx_data  <= rsp_data_q;
    end else if (i_mbx_tx_ready) begin
      o_mbx_tx_valid <= 1'b0;
    end
  end
  // Latest output frame is held so a Sync0 cycle applies the newest data
  always @(posedge i_clk) begin
    if (i_srst) begin
      pd_out_q      <= {PD_W{1'b0}};
      pd_out_seen_q <= 1'b0;
    end else if (i_pd_out_valid && pd_in_open) begin
      pd_out_q      <= i_pd_out_data;
      pd_out_seen_q <= 1'b1;
    end else if (!pd_in_open) begin
      pd_out_seen_q <= 1'b0;
    end
  end
  // One exchange per network cycle; outputs applied only in Operational
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_app_cycle     <= 1'b0;
      o_app_out_valid <= 1'b0;
      o_app_out_data  <= {PD_W{1'b0}};
      o_pd_in_valid   <= 1'b0;
      o_pd_in_data    <= {PD_W{1'b0}};
    end else begin
      o_app_cycle     <= net_cycle && pd_in_open;
      o_app_out_valid <= 1'b0;
      o_pd_in_valid   <= 1'b0;
      if (net_cycle && pd_in_open) begin
        o_pd_in_valid <= 1'b1;
        o_pd_in_data  <= i_app_in_data;
        if (pd_out_open && (pd_out_seen_q || i_pd_out_valid)) begin
          o_app_out_valid <= 1'b1;
          o_app_out_data  <= dc_mode_q ? pd_out_q : i_pd_out_data;
        end
      end
    end
  end

  // Interrupt events; a set in the clearing cycle wins
  assign irq_set[`FSSC_IRQ_STATE_CHG]   = wr_ctrl && o_bus_active &&
                                          trans_err == `FSSC_ERR_NONE &&
                                          req_state != state_q;
  assign irq_set[`FSSC_IRQ_TRANS_ERR]   = wr_ctrl && o_bus_active &&
                                          trans_err != `FSSC_ERR_NONE;
  assign irq_set[`FSSC_IRQ_EMCY_SENT]   = emcy_fire;
  assign irq_set[`FSSC_IRQ_SYNC_REFUSE] = sync_wr && !sync_ok;
  assign irq_clr = (i_wr && i_addr == `FSSC_ADDR_IRQ_CLR) ?
                   i_wdata[`FSSC_IRQ_W-1:0] : {`FSSC_IRQ_W{1'b0}};
  always @(posedge i_clk) begin
    if (i_srst) begin
      irq_stat_q <= {`FSSC_IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end
  assign o_irq = |(irq_stat_q & irq_en_q);

  // Read port: data stand for one cycle only; unmapped reads give zero
  always @(posedge i_clk) begin
    if (i_srst || !i_rd) begin
      o_rdata <= 32'h00000000;
    end else if (i_addr == `FSSC_ADDR_AL_CTRL) begin
      o_rdata <= {28'h0000000, req_q};
    end else if (i_addr == `FSSC_ADDR_AL_STAT) begin
      o_rdata <= {27'h0000000, err_q, state_q};
    end else if (i_addr == `FSSC_ADDR_AL_ERR) begin
      o_rdata <= {16'h0000, err_code_q};
    end else if (i_addr == `FSSC_ADDR_SYNC_MODE) begin
      o_rdata <= {31'h00000000, dc_mode_q};
    end else if (i_addr == `FSSC_ADDR_SYNC_PARAM) begin
      o_rdata <= {16'h0000, sync_param_q};
    end else if (i_addr == `FSSC_ADDR_BUS_SEL) begin
      o_rdata <= {28'h0000000, bus_sel_q};
    end else if (i_addr == `FSSC_ADDR_NODE) begin
      o_rdata <= {17'h00000, node_act_q, 1'b0, node_pend_q};
    end else if (i_addr == `FSSC_ADDR_IRQ_STAT) begin
      o_rdata <= {{(32-`FSSC_IRQ_W){1'b0}}, irq_stat_q};
    end else if (i_addr == `FSSC_ADDR_IRQ_EN) begin
      o_rdata <= {{(32-`FSSC_IRQ_W){1'b0}}, irq_en_q};
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule

// File: logic/fssc_regs.vh
// Register map, field codes and reset values of the fieldbus slave state control
`ifndef FSSC_REGS_VH
`define FSSC_REGS_VH

// Register offsets (byte addresses)
`define FSSC_ADDR_AL_CTRL    8'h00
`define FSSC_ADDR_AL_STAT    8'h04
`define FSSC_ADDR_AL_ERR     8'h08
`define FSSC_ADDR_SYNC_MODE  8'h0C
`define FSSC_ADDR_SYNC_PARAM 8'h10
`define FSSC_ADDR_BUS_SEL    8'h14
`define FSSC_ADDR_NODE       8'h18
`define FSSC_ADDR_IRQ_STAT   8'h1C
`define FSSC_ADDR_IRQ_EN     8'h20
`define FSSC_ADDR_IRQ_CLR    8'h24

// Communication state codes
`define FSSC_ST_INIT   4'h1
`define FSSC_ST_PREOP  4'h2
`define FSSC_ST_SAFEOP 4'h4
`define FSSC_ST_OP     4'h8

// Transition error codes, zero means accepted
`define FSSC_ERR_NONE    16'h0000
`define FSSC_ERR_BADREQ  16'h0011
`define FSSC_ERR_MBX_CFG 16'h0016
`define FSSC_ERR_PD_CFG  16'h001D
`define FSSC_ERR_DC_CFG  16'h0030

// Mailbox service codes
`define FSSC_SVC_EMCY    4'h1
`define FSSC_SVC_SDO_REQ 4'h2
`define FSSC_SVC_SDO_RSP 4'h3

// Fields
`define FSSC_AL_ERR_BIT      4
`define FSSC_SYNC_SUB_MSB    23
`define FSSC_SYNC_SUB_LSB    16
`define FSSC_SYNC_SETTABLE   8'h03
`define FSSC_BUS_SEL_THIS    4'h1
`define FSSC_NODE_ACT_LSB    8

// Interrupt bit positions
`define FSSC_IRQ_STATE_CHG   0
`define FSSC_IRQ_TRANS_ERR   1
`define FSSC_IRQ_EMCY_SENT   2
`define FSSC_IRQ_SYNC_REFUSE 3
`define FSSC_IRQ_W           4

// Reset values
`define FSSC_RST_BUS_SEL     4'h1
`define FSSC_RST_NODE        7'h00
`define FSSC_RST_SYNC_PARAM  16'h0000

`endif

// File: verif/fssc_props.sv
// Port checker of the fieldbus slave state control
`timescale 1ns/1ps
`include "fssc_regs.vh"
module fssc_props #(
  parameter PD_W = 32,
  parameter MB_W = 16
) (
  input wire logic            i_clk,
  input wire logic            i_srst,
  input wire logic            i_wr,
  input wire logic [3:0]      o_al_state,
  input wire logic            o_bus_active,
  input wire logic            i_mbx_rx_valid,
  input wire logic [3:0]      i_mbx_rx_svc,
  input wire logic [MB_W-1:0] i_mbx_rx_data,
  input wire logic            o_mbx_rx_ack,
  input wire logic            o_mbx_rx_nak,
  input wire logic            o_sdo_req_valid,
  input wire logic [MB_W-1:0] o_sdo_req_data,
  input wire logic            o_pd_in_valid,
  input wire logic            o_app_out_valid,
  input wire logic            o_mbx_tx_valid,
  input wire logic [3:0]      o_mbx_tx_svc,
  input wire logic [MB_W-1:0] o_mbx_tx_data,
  input wire logic            i_mbx_tx_ready,
  input wire logic            o_axis_forced,
  input wire logic [6:0]      o_axis_number
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_pd_in_gate: assert property (
    o_pd_in_valid |-> $past(o_al_state) inside {`FSSC_ST_SAFEOP, `FSSC_ST_OP})
    else $error("process inputs sent outside SafeOp and Op");
  a_out_gate: assert property (
    o_app_out_valid |-> $past(o_al_state) == `FSSC_ST_OP)
    else $error("outputs applied outside Op");
  a_init_nak: assert property (
    i_mbx_rx_valid && o_al_state == `FSSC_ST_INIT |=> o_mbx_rx_nak && !o_mbx_rx_ack)
    else $error("mailbox served in Init");
  a_sdo_ack: assert property (
    i_mbx_rx_valid && o_al_state != `FSSC_ST_INIT && i_mbx_rx_svc == `FSSC_SVC_SDO_REQ
    |=> o_mbx_rx_ack && o_sdo_req_valid && o_sdo_req_data == $past(i_mbx_rx_data))
    else $error("SDO request not passed on");
  a_state_hold: assert property (
    !$past(i_wr) && $past(o_bus_active) |-> $stable(o_al_state))
    else $error("state changed without request");
  a_tx_hold: assert property (
    o_mbx_tx_valid && !i_mbx_tx_ready
    |=> o_mbx_tx_valid && $stable(o_mbx_tx_data) && $stable(o_mbx_tx_svc))
    else $error("mailbox message dropped before ready");
  a_bus_init: assert property (
    !o_bus_active ##1 !o_bus_active |-> o_al_state == `FSSC_ST_INIT)
    else $error("deselected bus not in Init");
  a_axis_zero: assert property (
    !o_axis_forced |=> o_axis_number == 7'h00)
    else $error("axis number forced without node number");
endmodule

bind fssc_ctrl fssc_props #(.PD_W(PD_W), .MB_W(MB_W)) props_u (
  .i_clk(i_clk), .i_srst(i_srst), .i_wr(i_wr), .o_al_state(o_al_state),
  .o_bus_active(o_bus_active), .i_mbx_rx_valid(i_mbx_rx_valid),
  .i_mbx_rx_svc(i_mbx_rx_svc), .i_mbx_rx_data(i_mbx_rx_data), .o_mbx_rx_ack(o_mbx_rx_ack),
  .o_mbx_rx_nak(o_mbx_rx_nak), .o_sdo_req_valid(o_sdo_req_valid),
  .o_sdo_req_data(o_sdo_req_data), .o_pd_in_valid(o_pd_in_valid),
  .o_app_out_valid(o_app_out_valid), .o_mbx_tx_valid(o_mbx_tx_valid),
  .o_mbx_tx_svc(o_mbx_tx_svc), .o_mbx_tx_data(o_mbx_tx_data),
  .i_mbx_tx_ready(i_mbx_tx_ready), .o_axis_forced(o_axis_forced),
  .o_axis_number(o_axis_number));

// File: verif/fssc_master_model.sv
// Master side model: cyclic output frames, Sync0 events, mailbox sink
`timescale 1ns/1ps
module fssc_master_model (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_run,
  input  wire logic        i_stall,
  output logic             o_sync0,
  output logic             o_pd_valid,
  output logic [31:0]      o_pd_data,
  output logic             o_tx_ready
);
  logic [2:0] cyc_q;
  always @(posedge i_clk) begin
    cyc_q      <= i_srst ? 3'h0 : cyc_q + 3'h1;
    o_pd_valid <= i_run && cyc_q == 3'h0;
    o_sync0    <= i_run && cyc_q == 3'h4;
    o_tx_ready <= !i_stall;
    // Between frames the data lines are not valid, so show changing junk
    if (i_srst)
      o_pd_data <= 32'h12340000;
    else if (i_run && cyc_q == 3'h0)
      o_pd_data <= o_pd_data + 32'h01010101;
    else
      o_pd_data <= ~o_pd_data;
  end
endmodule

// File: verif/fssc_ctrl_tb.sv
// Self-checking bench of the fieldbus slave state control
`timescale 1ns/1ps
`include "fssc_regs.vh"
module fssc_ctrl_tb;
  logic        i_clk, i_srst, i_wr, i_rd, i_mbx_sm_ok, i_pd_sm_ok, i_dc_ok, i_restart;
  logic        i_node_unique, i_mbx_rx_valid, i_sdo_rsp_valid, i_alarm, run, stall, dc, ev_d;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, i_app_in_data, last_fr, prev;
  logic [3:0]  i_mbx_rx_svc;
  logic [15:0] i_mbx_rx_data, i_sdo_rsp_data, i_alarm_code;
  wire  [31:0] o_rdata, o_app_out_data, o_pd_in_data, i_pd_out_data;
  wire  [15:0] o_sdo_req_data, o_mbx_tx_data;
  wire  [6:0]  o_axis_number;
  wire  [3:0]  o_al_state, o_mbx_tx_svc;
  wire         o_irq, o_bus_active, o_axis_forced, o_mbx_rx_ack, o_mbx_rx_nak, o_sdo_req_valid;
  wire         o_mbx_tx_valid, o_app_cycle, o_app_out_valid, o_pd_in_valid;
  wire         i_sync0, i_pd_out_valid, i_mbx_tx_ready;
  int          fails, checks_done;

  fssc_ctrl dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_mbx_sm_ok(i_mbx_sm_ok),
    .i_pd_sm_ok(i_pd_sm_ok), .i_dc_ok(i_dc_ok), .i_restart(i_restart),
    .i_node_unique(i_node_unique), .o_bus_active(o_bus_active), .o_al_state(o_al_state),
    .o_axis_forced(o_axis_forced), .o_axis_number(o_axis_number),
    .i_mbx_rx_valid(i_mbx_rx_valid), .i_mbx_rx_svc(i_mbx_rx_svc),
    .i_mbx_rx_data(i_mbx_rx_data), .o_mbx_rx_ack(o_mbx_rx_ack), .o_mbx_rx_nak(o_mbx_rx_nak),
    .o_sdo_req_valid(o_sdo_req_valid), .o_sdo_req_data(o_sdo_req_data),
    .i_sdo_rsp_valid(i_sdo_rsp_valid), .i_sdo_rsp_data(i_sdo_rsp_data),
    .o_mbx_tx_valid(o_mbx_tx_valid), .o_mbx_tx_svc(o_mbx_tx_svc),
    .o_mbx_tx_data(o_mbx_tx_data), .i_mbx_tx_ready(i_mbx_tx_ready), .i_alarm(i_alarm),
    .i_alarm_code(i_alarm_code), .i_sync0(i_sync0), .i_pd_out_valid(i_pd_out_valid),
    .i_pd_out_data(i_pd_out_data), .i_app_in_data(i_app_in_data), .o_app_cycle(o_app_cycle),
    .o_app_out_valid(o_app_out_valid), .o_app_out_data(o_app_out_data),
    .o_pd_in_valid(o_pd_in_valid), .o_pd_in_data(o_pd_in_data));

  fssc_master_model master_u (.i_clk(i_clk), .i_srst(i_srst), .i_run(run), .i_stall(stall),
    .o_sync0(i_sync0), .o_pd_valid(i_pd_out_valid), .o_pd_data(i_pd_out_data),
    .o_tx_ready(i_mbx_tx_ready));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Last frame and the cycle event, as the slave should have seen them
  always @(posedge i_clk) begin
    ev_d <= dc ? i_sync0 : i_pd_out_valid;
    if (i_pd_out_valid)
      last_fr <= i_pd_out_data;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic restart;
    @(posedge i_clk);
    i_restart <= 1'b1;
    @(posedge i_clk);
    i_restart <= 1'b0;
    step(2);
  endtask

  task automatic mbx(input logic [3:0] s, input logic [15:0] d, input logic ok);
    @(posedge i_clk);
    i_mbx_rx_valid <= 1'b1;
    i_mbx_rx_svc <= s;
    i_mbx_rx_data <= d;
    @(posedge i_clk);
    i_mbx_rx_valid <= 1'b0;
    #1;
    chk(o_mbx_rx_ack, ok);
    chk(o_mbx_rx_nak, !ok);
    chk(o_sdo_req_valid, ok);
    if (ok)
      chk(o_sdo_req_data, d);
  endtask

  // Waits a bounded span for an application cycle
  task automatic pdw(input logic en, input logic ov);
    logic seen;
    seen = 1'b0;
    repeat (20) if (!seen) begin
      @(posedge i_clk);
      #1;
      seen = o_app_cycle;
    end
    chk(seen, en);
    if (seen) begin
      chk(ev_d, 1'b1);
      chk(o_pd_in_valid, 1'b1);
      chk(o_pd_in_data, i_app_in_data);
      chk(o_app_out_valid, ov);
      if (ov)
        chk(o_app_out_data, last_fr);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {i_wr, i_rd, i_mbx_sm_ok, i_pd_sm_ok, i_dc_ok, i_restart, i_mbx_rx_valid} = 7'h00;
    {i_sdo_rsp_valid, i_alarm, run, stall, dc} = 5'h00;
    {i_addr, i_wdata, i_mbx_rx_svc, i_mbx_rx_data, i_sdo_rsp_data, i_alarm_code} = 92'h0;
    {fails, checks_done, prev} = 96'h0;
    i_srst = 1'b1;
    i_node_unique = 1'b1;
    i_app_in_data = 32'hA5A50F0F;
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    restart;
    chk(o_axis_forced, 1'b0);
    rd(`FSSC_ADDR_BUS_SEL, 32'h1);
    chk(o_bus_active, 1'b1);
    for (int n = 13; n <= 127; n += 114) begin
      wr(`FSSC_ADDR_NODE, n);
      chk(o_axis_number, prev);
      restart;
      prev = n - 1;
      chk(o_axis_number, prev);
    end
    rd(`FSSC_ADDR_NODE, 32'h7F7F);
    mbx(`FSSC_SVC_SDO_REQ, 16'h1111, 1'b0);
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_SAFEOP);
    rd(`FSSC_ADDR_AL_STAT, 32'h11);
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_PREOP);
    rd(`FSSC_ADDR_AL_ERR, `FSSC_ERR_MBX_CFG);
    i_mbx_sm_ok <= 1'b1;
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_PREOP);
    rd(`FSSC_ADDR_AL_STAT, 32'h2);
    for (int s = 1; s <= 3; s++)
      mbx(s, 16'h2200 + s, s == 2);
    run <= 1'b1;
    pdw(1'b0, 1'b0);
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_SAFEOP);
    rd(`FSSC_ADDR_AL_ERR, `FSSC_ERR_PD_CFG);
    wr(`FSSC_ADDR_SYNC_MODE, 32'h1);
    dc <= 1'b1;
    i_pd_sm_ok <= 1'b1;
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_SAFEOP);
    rd(`FSSC_ADDR_AL_ERR, `FSSC_ERR_DC_CFG);
    i_dc_ok <= 1'b1;
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_SAFEOP);
    rd(`FSSC_ADDR_AL_STAT, 32'h4);
    pdw(1'b1, 1'b0);
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_OP);
    rd(`FSSC_ADDR_AL_STAT, 32'h8);
    pdw(1'b1, 1'b1);
    wr(`FSSC_ADDR_SYNC_PARAM, 32'h00031234);
    wr(`FSSC_ADDR_SYNC_PARAM, 32'h00045678);
    rd(`FSSC_ADDR_SYNC_PARAM, 32'h1234);
    rd(`FSSC_ADDR_IRQ_STAT, 32'hB);
    wr(`FSSC_ADDR_IRQ_CLR, 32'hF);
    wr(`FSSC_ADDR_IRQ_EN, 32'h4);
    stall <= 1'b1;
    i_alarm <= 1'b1;
    i_alarm_code <= 16'hBEEF;
    @(posedge i_clk);
    i_alarm <= 1'b0;
    step(4);
    chk({o_mbx_tx_valid, o_mbx_tx_svc, o_mbx_tx_data}, 32'h11BEEF);
    chk(o_irq, 1'b1);
    wr(`FSSC_ADDR_IRQ_EN, 32'h0);
    chk(o_irq, 1'b0);
    rd(`FSSC_ADDR_IRQ_STAT, 32'h4);
    chk(o_mbx_tx_valid, 1'b1);
    stall <= 1'b0;
    step(3);
    chk(o_mbx_tx_valid, 1'b0);
    i_sdo_rsp_valid <= 1'b1;
    i_sdo_rsp_data <= 16'h5A5A;
    @(posedge i_clk);
    i_sdo_rsp_valid <= 1'b0;
    step(1);
    chk({o_mbx_tx_valid, o_mbx_tx_svc, o_mbx_tx_data}, 32'h135A5A);
    wr(`FSSC_ADDR_IRQ_EN, 32'h4);
    chk(o_irq, 1'b1);
    wr(`FSSC_ADDR_IRQ_CLR, 32'h4);
    chk(o_irq, 1'b0);
    rd(8'hFC, 32'h0);
    wr(`FSSC_ADDR_BUS_SEL, 32'h2);
    chk(o_bus_active, 1'b0);
    wr(`FSSC_ADDR_AL_CTRL, `FSSC_ST_PREOP);
    step(2);
    chk(o_al_state, `FSSC_ST_INIT);
    wr(`FSSC_ADDR_BUS_SEL, 32'h1);
    pdw(1'b0, 1'b0);
    end_sim;
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    end_sim;
  end
endmodule
